// ==== common/flic_defines.svh ====
// Purpose: Offsets, field positions, reset values and vectors of the
//          four-level interrupt controller.
// Assumes: Eight-bit special function register space.
// Notes:   Definitions only.
`ifndef FLIC_DEFINES_SVH
`define FLIC_DEFINES_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define FLIC_OFS_EN_MAIN 8'hA8
`define FLIC_OFS_HI_MAIN 8'hB7
`define FLIC_OFS_LO_MAIN 8'hB8
`define FLIC_OFS_EN_EXT 8'hE8
`define FLIC_OFS_HI_EXT 8'hF7
`define FLIC_OFS_LO_EXT 8'hF8

// ==========================================================================
// Field positions and masks
// ==========================================================================
`define FLIC_GATE_BIT 7
`define FLIC_MAIN_MASK 8'h7F
`define FLIC_EXT_MASK 8'h0F
`define FLIC_RESET_VAL 8'h00
`define FLIC_NUM_SRC 11
`define FLIC_TOP_LEVEL 2'h3

// ==========================================================================
// Vector addresses
// ==========================================================================
`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_TMR0 16'h000B
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_TMR1 16'h001B
`define FLIC_VEC_UART 16'h0023
`define FLIC_VEC_TMR2 16'h002B
`define FLIC_VEC_PCA 16'h0033
`define FLIC_VEC_CAN 16'h003B
`define FLIC_VEC_ADC 16'h0043
`define FLIC_VEC_CANOVF 16'h004B
`define FLIC_VEC_SPI 16'h0053

`endif

// ==== common/flic_pkg.sv ====
// Purpose: Types shared by the interrupt controller and its bench.
// Assumes: Nothing beyond the defines header.
// Notes:   Request vector order is the polling order, index 0 first.
package flic_pkg;

  // ========================================================================
  // Request bundle, one bit per source in polling order.
  // ========================================================================
  typedef struct packed {
    logic spi;
    logic canOvf;
    logic adc;
    logic can;
    logic timer2;
    logic uart;
    logic pca;
    logic timer1;
    logic ext1;
    logic timer0;
    logic ext0;
  } flic_req_s;

  // Accept answer toward the core.
  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [15:0] vector;
  } flic_ack_s;

  // Nesting tracker states.
  typedef enum logic [1:0] {FLIC_IDLE, FLIC_BUSY} flic_state_e;

endpackage

// ==== rtl/flic_controller.sv ====
// Purpose: Four-level interrupt controller with vector supply to the core.
// Assumes: Sources present level requests synchronous to clock; the core
//          pulses irqTake when it vectors and irqReturn at handler end.
// Notes:   Peripheral flag logic stays in the peripherals.
// How it works
// - Gate bit 7 blocks every request.
// - Per-source enable masks one source.
// - Level is high bit then low bit.
// - Only strictly higher level preempts running handler.
// - Level three handler is never preempted.
// - Higher level wins among simultaneous requests.
// - Equal levels resolved by fixed polling order.
// - Fixed vector address for each source.
// - Shared flags are ORed into one request.
// - Main enable register layout, reset zero.
// - Extended enable holds four enables, reset zero.
// - Main low-level register seven bits, reset zero.
// - Extended low-level register four bits.
// - Bit writes leave neighbouring bits untouched.
// - High level bits in two further registers.
// - ADC request is done flag with enable.
`timescale 1ns/1ps
`default_nettype none
`include "flic_defines.svh"

module flic_controller
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic external_request_0,
  input wire logic external_request_1,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_overflow_flag,
  input wire logic pca_counter_overflow,
  input wire logic [4:0] pca_module_flags,
  input wire logic uart_rx_done,
  input wire logic uart_tx_done,
  input wire logic [3:0] canFlags,
  input wire logic can_timer_overflow,
  input wire logic adc_conversion_done,
  input wire logic spiFlag,
  input wire logic irqTake,
  input wire logic irqReturn,
  output var flic_pkg::flic_ack_s irqOut,
  output logic irqLine
);
  import flic_pkg::*;

  // ========================================================================
  // Register file
  // ========================================================================
  // Only the main enable register is a full-byte store, the others hold seven or four
  // bits; single-bit instructions reach us as read-modify-write from the core, so
  // neighbours are preserved.
  logic [7:0] enMain_reg, enMain_next; // Main enable register.
  logic [3:0] enExt_reg, enExt_next; // Extended enable register.
  logic [6:0] loMain_reg, loMain_next; // Main low-level bits.
  logic [3:0] loExt_reg, loExt_next; // Extended low-level bits.
  logic [6:0] hiMain_reg, hiMain_next; // Main high-level bits.
  logic [3:0] hiExt_reg, hiExt_next; // Extended high-level bits.
  logic [7:0] rdData_reg, rdData_next; // Registered read answer.

  // Write decode: only the addressed register changes.
  always_comb
  begin
    enMain_next = enMain_reg;
    enExt_next = enExt_reg;
    loMain_next = loMain_reg;
    loExt_next = loExt_reg;
    hiMain_next = hiMain_reg;
    hiExt_next = hiExt_reg;
    if (regWrite)
    begin
      case (regAddr)
        `FLIC_OFS_EN_MAIN: enMain_next = regWrData;
        `FLIC_OFS_EN_EXT: enExt_next = regWrData[3:0];
        `FLIC_OFS_LO_MAIN: loMain_next = regWrData[6:0];
        `FLIC_OFS_LO_EXT: loExt_next = regWrData[3:0];
        `FLIC_OFS_HI_MAIN: hiMain_next = regWrData[6:0];
        `FLIC_OFS_HI_EXT: hiExt_next = regWrData[3:0];
        default: ; // Unmapped writes are dropped.
      endcase
    end
  end

  // Read decode; reserved bits read zero, which software must not rely on.
  always_comb
  begin
    rdData_next = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        `FLIC_OFS_EN_MAIN: rdData_next = enMain_reg;
        `FLIC_OFS_EN_EXT: rdData_next = {4'h0, enExt_reg};
        `FLIC_OFS_LO_MAIN: rdData_next = {1'b0, loMain_reg};
        `FLIC_OFS_LO_EXT: rdData_next = {4'h0, loExt_reg};
        `FLIC_OFS_HI_MAIN: rdData_next = {1'b0, hiMain_reg};
        `FLIC_OFS_HI_EXT: rdData_next = {4'h0, hiExt_reg};
        default: rdData_next = 8'h00; // Unmapped reads return zero.
      endcase
    end
  end

  // Register storage.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      enMain_reg <= `FLIC_RESET_VAL;
      enExt_reg <= 4'h0;
      loMain_reg <= 7'h00;
      loExt_reg <= 4'h0;
      hiMain_reg <= 7'h00;
      hiExt_reg <= 4'h0;
      rdData_reg <= 8'h00;
    end
    else
    begin
      enMain_reg <= enMain_next;
      enExt_reg <= enExt_next;
      loMain_reg <= loMain_next;
      loExt_reg <= loExt_next;
      hiMain_reg <= hiMain_next;
      hiExt_reg <= hiExt_next;
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // ========================================================================
  // External pin synchronisers
  // ========================================================================
  // Two flops each; only the second stage is read by logic.
  logic [1:0] extMeta_reg, extSync_reg;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      extMeta_reg <= 2'b00;
      extSync_reg <= 2'b00;
    end
    else
    begin
      extMeta_reg <= {external_request_1, external_request_0};
      extSync_reg <= extMeta_reg;
    end
  end

  // ========================================================================
  // Request gathering, enables and levels
  // ========================================================================
  flic_req_s rawReq; // Source requests in polling order.
  flic_req_s enBits; // Matching enable bits.
  logic [10:0] liveReq; // Enabled requests past the gate.
  logic [1:0] srcLevel [0:10]; // Level of each source.
  logic [15:0] srcVector [0:10]; // Vector of each source.

  always_comb
  begin
    rawReq.ext0 = extSync_reg[0];
    rawReq.timer0 = timer0_overflow_flag;
    rawReq.ext1 = extSync_reg[1];
    rawReq.timer1 = timer1_overflow_flag;
    rawReq.pca = pca_counter_overflow | (|pca_module_flags);
    rawReq.uart = uart_rx_done | uart_tx_done;
    rawReq.timer2 = timer2_overflow_flag;
    rawReq.can = |canFlags;
    rawReq.adc = adc_conversion_done;
    rawReq.canOvf = can_timer_overflow;
    rawReq.spi = spiFlag;
    enBits.ext0 = enMain_reg[0];
    enBits.timer0 = enMain_reg[1];
    enBits.ext1 = enMain_reg[2];
    enBits.timer1 = enMain_reg[3];
    enBits.uart = enMain_reg[4];
    enBits.timer2 = enMain_reg[5];
    enBits.pca = enMain_reg[6];
    enBits.can = enExt_reg[0];
    enBits.adc = enExt_reg[1];
    enBits.canOvf = enExt_reg[2];
    enBits.spi = enExt_reg[3];
    liveReq = rawReq & enBits & {11{enMain_reg[`FLIC_GATE_BIT]}};
    // Polling slot to register bit mapping; level = {high, low}.
    srcLevel[0] = {hiMain_reg[0], loMain_reg[0]};
    srcLevel[1] = {hiMain_reg[1], loMain_reg[1]};
    srcLevel[2] = {hiMain_reg[2], loMain_reg[2]};
    srcLevel[3] = {hiMain_reg[3], loMain_reg[3]};
    srcLevel[4] = {hiMain_reg[6], loMain_reg[6]};
    srcLevel[5] = {hiMain_reg[4], loMain_reg[4]};
    srcLevel[6] = {hiMain_reg[5], loMain_reg[5]};
    srcLevel[7] = {hiExt_reg[0], loExt_reg[0]};
    srcLevel[8] = {hiExt_reg[1], loExt_reg[1]};
    srcLevel[9] = {hiExt_reg[2], loExt_reg[2]};
    srcLevel[10] = {hiExt_reg[3], loExt_reg[3]};
    srcVector[0] = `FLIC_VEC_EXT0;
    srcVector[1] = `FLIC_VEC_TMR0;
    srcVector[2] = `FLIC_VEC_EXT1;
    srcVector[3] = `FLIC_VEC_TMR1;
    srcVector[4] = `FLIC_VEC_PCA;
    srcVector[5] = `FLIC_VEC_UART;
    srcVector[6] = `FLIC_VEC_TMR2;
    srcVector[7] = `FLIC_VEC_CAN;
    srcVector[8] = `FLIC_VEC_ADC;
    srcVector[9] = `FLIC_VEC_CANOVF;
    srcVector[10] = `FLIC_VEC_SPI;
  end

  // ========================================================================
  // Arbitration
  // ========================================================================
  // Scanning from the last slot down, a candidate replaces the best only
  // when its level is at least as high, so the lowest slot wins ties.
  logic winValid; // Some enabled request exists.
  logic [1:0] winLevel; // Level of the winner.
  logic [15:0] winVector; // Vector of the winner.

  always_comb
  begin
    winValid = 1'b0;
    winLevel = 2'b00;
    winVector = 16'h0000;
    for (int i = `FLIC_NUM_SRC - 1; i >= 0; i--)
    begin
      if (liveReq[i] && (!winValid || srcLevel[i] >= winLevel))
      begin
        winValid = 1'b1;
        winLevel = srcLevel[i];
        winVector = srcVector[i];
      end
    end
  end

  // ========================================================================
  // In-service tracking
  // ========================================================================
  // One bit per level; the highest set bit is the running level. A bit
  // stack keeps nesting exact without storing a history of vectors.
  logic [3:0] inSvc_reg, inSvc_next; // Levels currently in service.
  flic_state_e state_reg, state_next; // Any handler running.
  logic canPreempt; // Winner outranks the running handler.
  logic [3:0] topMask; // Highest in-service bit only.

  always_comb
  begin
    topMask = 4'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (inSvc_reg[l])
      begin
        topMask = 4'h0;
        topMask[l] = 1'b1;
      end
    end
    canPreempt = 1'b1;
    for (int l = 0; l < 4; l++)
    begin
      if (inSvc_reg[l] && (winLevel <= 2'(l)))
      begin
        canPreempt = 1'b0;
      end
    end
    inSvc_next = inSvc_reg;
    if (irqReturn)
    begin
      inSvc_next = inSvc_next & ~topMask;
    end
    if (irqTake && irqOut.valid)
    begin
      inSvc_next[winLevel] = 1'b1;
    end
    state_next = (inSvc_next != 4'h0) ? FLIC_BUSY : FLIC_IDLE;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      inSvc_reg <= 4'h0;
      state_reg <= FLIC_IDLE;
    end
    else
    begin
      inSvc_reg <= inSvc_next;
      state_reg <= state_next;
    end
  end

  // Offer toward the core; a level-3 handler blocks all because no level
  // can exceed the top level.
  always_comb
  begin
    case (state_reg)
      FLIC_IDLE: irqOut.valid = winValid;
      FLIC_BUSY: irqOut.valid = winValid && canPreempt;
      default: irqOut.valid = 1'b0;
    endcase
    irqOut.level = winLevel;
    irqOut.vector = winVector;
    irqLine = irqOut.valid;
  end

endmodule // flic_controller
`default_nettype wire

// ==== verif/flic_controller_assertions.sv ====
// Purpose: Port-level checks of the interrupt controller.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes:   The gate bit is mirrored from bus writes.
`timescale 1ns/1ps
`default_nettype none
module flic_controller_assertions
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic irqTake,
  input wire flic_pkg::flic_ack_s irqOut,
  input wire logic irqLine
);
  import flic_pkg::*;
  // ==========================================================
  // Helper logic
  // ==========================================================
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic gateReg; // Mirror of the global gate.
  logic gateNext; // Its next value.
  // Follow writes to the main enable register.
  always_comb
    gateNext = (regWrite && regAddr == 8'hA8) ? regWrData[7] : gateReg;
  always_ff @(posedge clock or posedge reset)
    if (reset)
      gateReg <= 1'b0;
    else
      gateReg <= gateNext;
  // A vector accepted by the core, and one at the top level.
  sequence takeSeq;
    irqTake && irqOut.valid;
  endsequence
  sequence topTake;
    takeSeq ##0 irqOut.level == 2'h3;
  endsequence
  // ==========================================================
  // Assertions
  // ==========================================================
  a_line_follows: assert property (irqLine == irqOut.valid)
    else $error("irq line differs from offer");
  a_gate_blocks: assert property (!gateReg |-> !irqLine)
    else $error("request passed a closed gate");
  a_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (regRead && !(regAddr inside
    {8'hA8, 8'hB7, 8'hB8, 8'hE8, 8'hF7, 8'hF8}) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_ext: assert property (regRead && regAddr inside
    {8'hE8, 8'hF7, 8'hF8} |=> regRdData[7:4] == 4'h0)
    else $error("reserved upper bits set");
  a_rsvd_main: assert property (regRead && regAddr inside
    {8'hB7, 8'hB8} |=> !regRdData[7])
    else $error("reserved bit 7 set");
  a_vec_legal: assert property (irqOut.valid |-> irqOut.vector inside
    {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
     16'h0033, 16'h003B, 16'h0043, 16'h004B, 16'h0053})
    else $error("vector outside table");
  a_top_holds: assert property (topTake |=> !irqLine)
    else $error("top level handler preempted");
  a_preempt_higher: assert property (takeSeq ##1 irqOut.valid
    |-> irqOut.level > $past(irqOut.level))
    else $error("preemption without higher level");
endmodule // flic_controller_assertions
bind flic_controller flic_controller_assertions u_chk (.*);
`default_nettype wire

// ==== verif/flic_core_model.sv ====
// Purpose: Core side that vectors offers and ends handlers.
// Assumes: The bench commands each handler end.
// Notes:   takeDelay makes the core slow to accept.
`timescale 1ns/1ps
`default_nettype none
module flic_core_model
(
  input wire logic clock,
  input wire logic reset,
  input wire logic irqLine,
  input wire logic autoTake,
  input wire logic [3:0] takeDelay,
  input wire logic retReq,
  output logic irqTake,
  output logic irqReturn
);
  logic [3:0] waitReg; // Cycles the offer has stood.
  logic [3:0] waitNext; // Its next value.
  // Accept only while an offer stands and it has waited enough.
  assign irqTake = autoTake && irqLine && waitReg >= takeDelay;
  always_comb
    waitNext = (irqLine && !irqTake && waitReg != 4'hF) ?
      waitReg + 4'h1 : 4'h0;
  // Handler end is one cycle after the bench asks for it.
  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      waitReg <= 4'h0;
      irqReturn <= 1'b0;
    end
    else
    begin
      waitReg <= waitNext;
      irqReturn <= retReq;
    end
endmodule // flic_core_model
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Core model on the far side.
// Notes:   Random settings, then a hand-written nesting run.
`timescale 1ns/1ps
`default_nettype none
`include "flic_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import flic_pkg::*;
  localparam logic [15:0] VEC[11] = '{`FLIC_VEC_EXT0, `FLIC_VEC_TMR0,
    `FLIC_VEC_EXT1, `FLIC_VEC_TMR1, `FLIC_VEC_PCA, `FLIC_VEC_UART,
    `FLIC_VEC_TMR2, `FLIC_VEC_CAN, `FLIC_VEC_ADC, `FLIC_VEC_CANOVF,
    `FLIC_VEC_SPI};
  localparam int POS[11] = '{0, 1, 2, 3, 6, 4, 5, 8, 9, 10, 11};
  localparam logic [7:0] OFS[6] = '{`FLIC_OFS_EN_MAIN, `FLIC_OFS_HI_MAIN,
    `FLIC_OFS_LO_MAIN, `FLIC_OFS_EN_EXT, `FLIC_OFS_HI_EXT, `FLIC_OFS_LO_EXT};
  logic clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rdv;
  logic [7:0] regVal[6] = '{default: 8'h00}; // Expected contents.
  logic [10:0] req = 11'h000; // Requests in polling order.
  logic [5:0] sel = 6'h00; // Picks which shared flag carries a request.
  logic autoTake = 1'b0, retReq = 1'b0, irqTake, irqReturn, irqLine;
  logic [3:0] takeDelay = 4'h0;
  logic [15:0] takenVec = 16'h0000, en = 16'h0000, lo = 16'h0000;
  logic [15:0] hi = 16'h0000;
  flic_ack_s irqOut;
  int err_count = 0, compares = 0;
  flic_controller u_dut (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .external_request_0(req[0]),
    .external_request_1(req[2]), .timer0_overflow_flag(req[1]),
    .timer1_overflow_flag(req[3]), .timer2_overflow_flag(req[6]),
    .pca_counter_overflow(req[4] && sel[0]),
    .pca_module_flags((req[4] && !sel[0]) ? 5'h01 << sel[2:1] : 5'h00),
    .uart_rx_done(req[5] && sel[3]), .uart_tx_done(req[5] && !sel[3]),
    .canFlags(req[7] ? 4'h1 << sel[5:4] : 4'h0),
    .can_timer_overflow(req[9]), .adc_conversion_done(req[8]),
    .spiFlag(req[10]), .irqTake(irqTake), .irqReturn(irqReturn),
    .irqOut(irqOut), .irqLine(irqLine));
  flic_core_model u_core (.clock(clock), .reset(reset), .irqLine(irqLine),
    .autoTake(autoTake), .takeDelay(takeDelay), .retReq(retReq),
    .irqTake(irqTake), .irqReturn(irqReturn));
  initial
    forever #50 clock = ~clock;
  // Remember the vector of each accepted offer.
  always @(posedge clock)
    if (irqTake)
      takenVec <= irqOut.vector;
  // Winner for the current settings with nothing in service.
  function automatic flic_ack_s expAck(input logic [10:0] rq);
    flic_ack_s e;
    logic [1:0] l;
    e = '0;
    for (int i = 0; i < 11; i++)
    begin
      l = {hi[POS[i]], lo[POS[i]]};
      if (en[7] && en[POS[i]] && rq[i] && (!e.valid || l > e.level))
        e = {1'b1, l, VEC[i]};
    end
    return e;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rdv = regRdData;
    @(posedge clock);
  endtask
  // Write all six registers; chkRegs reads them back.
  task automatic setRegs;
    regVal = '{en[7:0], hi[7:0], lo[7:0], en[15:8], hi[15:8], lo[15:8]};
    for (int i = 0; i < 6; i++)
      wr(OFS[i], regVal[i]);
  endtask
  task automatic chkRegs;
    for (int i = 0; i < 6; i++)
    begin
      rd(OFS[i]);
      `CHK(rdv, regVal[i])
    end
  endtask
  task automatic conclude;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run.
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'habe6));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chkRegs();
    rd(8'h00);
    `CHK(rdv, 8'h00)
    repeat (150)
    begin
      en = 16'($urandom) & 16'h0FFF;
      en[7] = ($urandom_range(3, 0) != 0);
      hi = 16'($urandom) & 16'h0F7F;
      lo = 16'($urandom) & 16'h0F7F;
      setRegs();
      chkRegs();
      req <= 11'($urandom);
      sel <= 6'($urandom);
      repeat (3) @(posedge clock);
      #1 `CHK(irqOut, expAck(req))
    end
    // Nesting: uart at level 2, overrun and spi at level 3.
    req <= 11'h000;
    en = 16'h0FFF;
    hi = 16'h0C10;
    lo = 16'h0C00;
    setRegs();
    autoTake <= 1'b1;
    req <= 11'h002;
    repeat (4) @(posedge clock);
    #1 `CHK(takenVec, `FLIC_VEC_TMR0)
    takeDelay <= 4'h2;
    req <= 11'h00A;
    repeat (5) @(posedge clock);
    #1 `CHK(irqLine, 1'b0)
    req <= 11'h02A;
    repeat (6) @(posedge clock);
    #1 `CHK(takenVec, `FLIC_VEC_UART)
    req <= 11'h42A;
    repeat (6) @(posedge clock);
    #1 `CHK(takenVec, `FLIC_VEC_SPI)
    req <= 11'h62A;
    repeat (5) @(posedge clock);
    #1 `CHK(irqLine, 1'b0)
    req <= 11'h22A;
    retReq <= 1'b1;
    @(posedge clock);
    retReq <= 1'b0;
    repeat (7) @(posedge clock);
    #1 `CHK(takenVec, `FLIC_VEC_CANOVF)
    conclude();
  end
endmodule // tb
`default_nettype wire
